// ---- rmcb_pkg.sv ----
// Package for the RAM-mapped control bit area of a 4-bit controller core.
// Assumes the core drives bit operations on its own instruction clock.
package rmcb_pkg;

    // --------------------
    // Memory map
    // --------------------
    localparam logic [13:0] VEC_LAST_ADDR   = 14'h000f;
    localparam logic [13:0] ZPAGE_LAST_ADDR = 14'h003f;
    localparam logic [13:0] PAT_LAST_ADDR   = 14'h0fff;
    localparam logic [9:0]  IRQ_AREA_LAST   = 10'h003;
    localparam logic [9:0]  SPEC_A_LAST     = 10'h01f;
    localparam logic [9:0]  FLAG_AREA_FIRST = 10'h020;
    localparam logic [9:0]  FLAG_AREA_LAST  = 10'h023;
    localparam logic [9:0]  SPEC_B_FIRST    = 10'h024;
    localparam logic [9:0]  SPEC_B_LAST     = 10'h03f;
    localparam logic [9:0]  MEMREG_FIRST    = 10'h040;
    localparam logic [9:0]  MEMREG_LAST     = 10'h04f;
    localparam logic [9:0]  STACK_FIRST     = 10'h3c0;
    localparam logic [9:0]  STACK_TOP       = 10'h3ff;

    // --------------------
    // Register offsets
    // --------------------
    localparam logic [9:0] WAKEUP_AND_GLOBAL_IRQ_BITS = 10'h000;
    localparam logic [9:0] EXTERNAL_IRQ_BITS          = 10'h001;
    localparam logic [9:0] TIMER_A_B_IRQ_BITS         = 10'h002;
    localparam logic [9:0] CONVERTER_TIMER_C_IRQ_BITS = 10'h003;
    localparam logic [9:0] SYSTEM_FLAG_BITS           = 10'h020;
    localparam logic [9:0] GEAR_FLAG_BITS             = 10'h021;
    localparam logic [9:0] UNUSED_FLAG_SLOT           = 10'h022;
    localparam logic [9:0] SERIAL_IRQ_BITS            = 10'h023;

    // Reset values: masks 1, flags 0, enable 0
    localparam logic [3:0] RST_WAKEUP  = 4'h8;
    localparam logic [3:0] RST_EXT     = 4'h2;
    localparam logic [3:0] RST_TIMER   = 4'ha;
    localparam logic [3:0] RST_CONV    = 4'ha;
    localparam logic [3:0] RST_SYSTEM  = 4'h0;
    localparam logic [3:0] RST_GEAR    = 4'h0;
    localparam logic [3:0] RST_SERIAL  = 4'h8;

    // Per-bit access classes
    typedef enum logic [2:0] {
        RMCB_ACC_FULL   = 3'h0, // set, clear, test
        RMCB_ACC_FLAG   = 3'h1, // set ignored
        RMCB_ACC_NOTEST = 3'h2, // set, clear, no test
        RMCB_ACC_RSP    = 3'h3, // clear only, no test
        RMCB_ACC_WDOG   = 3'h4, // set only, no test
        RMCB_ACC_ADS    = 3'h5, // set, test
        RMCB_ACC_DIRECT_TRANSFER_ON   = 3'h6, // set in subactive only
        RMCB_ACC_NONE   = 3'h7  // nonexistent
    } rmcb_acc_e;

    // Bit instruction from the core
    typedef struct packed {
        logic       set_op;   // bit_set_op or bit_set_direct_op
        logic       clear_op; // bit_clear_op or bit_clear_direct_op
        logic       test_op;  // bit_test_op or bit_test_direct_op
        logic [9:0] addr;
        logic [1:0] bit_sel;
    } rmcb_bitop_s;

    // Hardware event inputs that raise request flags
    typedef struct packed {
        logic wakeup;
        logic ext;
        logic timer_a;
        logic timer_b;
        logic timer_c;
        logic adc;
        logic serial;
    } rmcb_evt_s;

    // Stack frame word, four digits
    typedef struct packed {
        logic [13:0] pc;
        logic        st;
        logic        ca;
    } rmcb_frame_s;

    // Program fetch request to the core: address and enable
    typedef struct packed {
        logic [13:0] fetch_addr;
        logic        fetch_en;
    } rmcb_fetch_s;

endpackage

// ---- rmcb_bits.sv ----
// RAM-mapped control bits, stack save/restore and map decode.
// Assumes a core issuing at most one bit op or stack op per cycle.
`timescale 1ns/100ps

module rmcb_bits #(
    parameter int MEM_WORDS = 1024
) (
    input  wire logic                  core_clk_in,
    input  wire logic                  reset_n_in,
    input  wire rmcb_pkg::rmcb_bitop_s bitop_in,
    input  wire rmcb_pkg::rmcb_evt_s   evt_in,
    input  wire logic                  subactive_in,
    input  wire logic                  call_in,
    input  wire logic                  irq_entry_in,
    input  wire logic [1:0]            irq_vec_in,
    input  wire logic                  sub_ret_in,
    input  wire logic                  irq_ret_in,
    input  wire logic [13:0]           pc_in,
    input  wire logic                  st_in,
    input  wire logic                  ca_in,
    input  wire logic                  short_call_in,
    input  wire logic [5:0]            short_target_in,
    input  wire logic                  pattern_in,
    input  wire logic [11:0]           pattern_addr_in,
    input  wire logic                  ram_we_in,
    input  wire logic [9:0]            ram_addr_in,
    input  wire logic [3:0]            ram_wdata_in,
    input  wire logic                  memreg_swap_in,
    input  wire logic [3:0]            memreg_idx_in,
    input  wire logic [3:0]            acc_in,
    output logic                       test_valid_out,
    output logic                       test_result_out,
    output logic                       test_undef_out,
    output logic [3:0]                 ram_rdata_out,
    output logic [3:0]                 memreg_out,
    output logic [9:0]                 stack_ptr_out,
    output rmcb_pkg::rmcb_frame_s      restore_out,
    output logic                       restore_valid_out,
    output logic                       restore_flags_out,
    output rmcb_pkg::rmcb_fetch_s      fetch_out,
    output logic [6:0]                 irq_pend_out,
    output logic                       global_irq_allow_out,
    output logic                       watchdog_run_out,
    output logic                       adc_start_out,
    output logic                       low_speed_out,
    output logic                       gear_enable_out,
    output logic                       direct_transfer_out
);

    // --------------------
    // State
    // --------------------
    logic [3:0] irq0_q, irq0_d, irq1_q, irq1_d, irq2_q, irq2_d;
    logic [3:0] irq3_q, irq3_d, sys_q, sys_d, gear_q, gear_d;
    logic [3:0] ser_q, ser_d;
    logic [6:0] pend_q, pend_d;
    logic [9:0] sp_q, sp_d;
    logic       tv_q, tv_d, tr_q, tr_d, tu_q, tu_d;
    logic [3:0] rdata_q, rdata_d, mr_q, mr_d;
    rmcb_pkg::rmcb_frame_s frame_q, frame_d;
    logic       rv_q, rv_d, rf_q, rf_d;
    rmcb_pkg::rmcb_fetch_s fetch_q, fetch_d;
    // Data RAM with no reset: contents undefined until written
    logic [3:0] ram_q [MEM_WORDS];
    logic [3:0] cur;
    logic [2:0] acc_cls;
    logic       in_area;

    // --------------------
    // Access class per bit and map decode
    // --------------------
    always_comb begin
        cur = 4'h0;
        acc_cls = rmcb_pkg::RMCB_ACC_NONE;
        in_area = 1'b1;
        case (bitop_in.addr)
            rmcb_pkg::WAKEUP_AND_GLOBAL_IRQ_BITS: begin
                cur = irq0_q;
                case (bitop_in.bit_sel)
                    2'd0: acc_cls = rmcb_pkg::RMCB_ACC_FULL;
                    2'd1: acc_cls = rmcb_pkg::RMCB_ACC_RSP;
                    2'd2: acc_cls = rmcb_pkg::RMCB_ACC_FLAG;
                    default: acc_cls = rmcb_pkg::RMCB_ACC_FULL;
                endcase
            end
            rmcb_pkg::EXTERNAL_IRQ_BITS: begin
                cur = irq1_q;
                case (bitop_in.bit_sel)
                    2'd0: acc_cls = rmcb_pkg::RMCB_ACC_FLAG;
                    2'd1: acc_cls = rmcb_pkg::RMCB_ACC_FULL;
                    default: acc_cls = rmcb_pkg::RMCB_ACC_NONE;
                endcase
            end
            rmcb_pkg::TIMER_A_B_IRQ_BITS,
            rmcb_pkg::CONVERTER_TIMER_C_IRQ_BITS: begin
                cur = (bitop_in.addr[0]) ? irq3_q : irq2_q;
                acc_cls = bitop_in.bit_sel[0] ? rmcb_pkg::RMCB_ACC_FULL
                                              : rmcb_pkg::RMCB_ACC_FLAG;
            end
            rmcb_pkg::SYSTEM_FLAG_BITS: begin
                cur = sys_q;
                case (bitop_in.bit_sel)
                    2'd0: acc_cls = rmcb_pkg::RMCB_ACC_FULL;
                    2'd1: acc_cls = rmcb_pkg::RMCB_ACC_WDOG;
                    2'd2: acc_cls = rmcb_pkg::RMCB_ACC_ADS;
                    default: acc_cls = rmcb_pkg::RMCB_ACC_DIRECT_TRANSFER_ON;
                endcase
            end
            rmcb_pkg::GEAR_FLAG_BITS: begin
                cur = gear_q;
                acc_cls = (bitop_in.bit_sel == 2'd3)
                        ? rmcb_pkg::RMCB_ACC_NOTEST
                        : rmcb_pkg::RMCB_ACC_NONE;
            end
            rmcb_pkg::UNUSED_FLAG_SLOT: acc_cls = rmcb_pkg::RMCB_ACC_NONE;
            rmcb_pkg::SERIAL_IRQ_BITS: begin
                cur = ser_q;
                case (bitop_in.bit_sel)
                    2'd3: acc_cls = rmcb_pkg::RMCB_ACC_FULL;
                    2'd2: acc_cls = rmcb_pkg::RMCB_ACC_FLAG;
                    default: acc_cls = rmcb_pkg::RMCB_ACC_NONE;
                endcase
            end
            // Special registers and other RAM take no bit ops
            default: in_area = 1'b0;
        endcase
    end

    // --------------------
    // Bit operations, events, stack and fetch next state
    // --------------------
    always_comb begin
        logic [3:0] nv;
        logic       do_set, do_clr;
        nv = cur;
        irq0_d = irq0_q;
        irq1_d = irq1_q;
        irq2_d = irq2_q;
        irq3_d = irq3_q;
        sys_d = sys_q;
        gear_d = gear_q;
        ser_d = ser_q;
        sp_d = sp_q;
        tv_d = 1'b0;
        tr_d = tr_q;
        tu_d = 1'b0;
        rv_d = 1'b0;
        rf_d = 1'b0;
        frame_d = frame_q;
        fetch_d = '0;
        rdata_d = ram_q[ram_addr_in];
        // Bit ops outside the areas change no bits
        do_set = in_area && bitop_in.set_op;
        do_clr = in_area && bitop_in.clear_op;
        case (acc_cls)
            rmcb_pkg::RMCB_ACC_FLAG: do_set = 1'b0;
            rmcb_pkg::RMCB_ACC_RSP:  do_set = 1'b0;
            rmcb_pkg::RMCB_ACC_WDOG: do_clr = 1'b0;
            rmcb_pkg::RMCB_ACC_ADS:  do_clr = 1'b0;
            rmcb_pkg::RMCB_ACC_DIRECT_TRANSFER_ON:
                do_set = do_set && subactive_in;
            rmcb_pkg::RMCB_ACC_NONE: begin
                do_set = 1'b0;
                do_clr = 1'b0;
            end
            default: ;
        endcase
        if (do_set) nv[bitop_in.bit_sel] = 1'b1;
        if (do_clr) nv[bitop_in.bit_sel] = 1'b0;
        if (do_set || do_clr) begin
            case (bitop_in.addr)
                rmcb_pkg::WAKEUP_AND_GLOBAL_IRQ_BITS: irq0_d = nv;
                rmcb_pkg::EXTERNAL_IRQ_BITS:          irq1_d = nv;
                rmcb_pkg::TIMER_A_B_IRQ_BITS:         irq2_d = nv;
                rmcb_pkg::CONVERTER_TIMER_C_IRQ_BITS: irq3_d = nv;
                rmcb_pkg::SYSTEM_FLAG_BITS:           sys_d = nv;
                rmcb_pkg::GEAR_FLAG_BITS:             gear_d = nv;
                default:                              ser_d = nv;
            endcase
        end
        // Active mode forces direct transfer low
        if (!subactive_in) sys_d[3] = 1'b0;
        // Hardware events win over a same-cycle clear; pending follows
        irq0_d[2] = irq0_d[2] | evt_in.wakeup;
        irq1_d[0] = irq1_d[0] | evt_in.ext;
        irq2_d[0] = irq2_d[0] | evt_in.timer_a;
        irq2_d[2] = irq2_d[2] | evt_in.timer_b;
        irq3_d[0] = irq3_d[0] | evt_in.timer_c;
        irq3_d[2] = irq3_d[2] | evt_in.adc;
        ser_d[2]  = ser_d[2]  | evt_in.serial;
        pend_d = {irq0_d[2] & ~irq0_d[3], irq1_d[0] & ~irq1_d[1],
                  irq2_d[0] & ~irq2_d[1], irq2_d[2] & ~irq2_d[3],
                  irq3_d[0] & ~irq3_d[1], irq3_d[2] & ~irq3_d[3],
                  ser_d[2] & ~ser_d[3]};
        // Bit test; forbidden or missing bit flagged undefined
        if (in_area && bitop_in.test_op) begin
            tv_d = 1'b1;
            tr_d = cur[bitop_in.bit_sel];
            tu_d = acc_cls inside {rmcb_pkg::RMCB_ACC_NOTEST,
                rmcb_pkg::RMCB_ACC_RSP, rmcb_pkg::RMCB_ACC_WDOG,
                rmcb_pkg::RMCB_ACC_NONE};
        end
        // Stack clear bit cleared reloads pointer
        if (do_clr && acc_cls == rmcb_pkg::RMCB_ACC_RSP)
            sp_d = rmcb_pkg::STACK_TOP;
        // Save frame, four digits down per level
        else if (call_in || irq_entry_in)
            sp_d = {4'hf, 6'(sp_q[5:0] - 6'h04)};
        else if (sub_ret_in || irq_ret_in) begin
            sp_d = {4'hf, 6'(sp_q[5:0] + 6'h04)};
            rv_d = 1'b1;
            rf_d = irq_ret_in; // Flags restored only on irq return
            frame_d = {ram_q[{4'hf, 6'(sp_q[5:0] + 6'h04)}][3:0],
                       ram_q[{4'hf, 6'(sp_q[5:0] + 6'h03)}][3:0],
                       ram_q[{4'hf, 6'(sp_q[5:0] + 6'h02)}][3:0],
                       ram_q[{4'hf, 6'(sp_q[5:0] + 6'h01)}][3:0]};
        end
        // Vector fetch on interrupt entry
        if (irq_entry_in) begin
            fetch_d.fetch_en = 1'b1;
            fetch_d.fetch_addr = {10'h000, irq_vec_in, 2'b00}
                               & rmcb_pkg::VEC_LAST_ADDR;
        end else if (short_call_in) begin
            fetch_d.fetch_en = 1'b1; // Zero page only
            fetch_d.fetch_addr = {8'h00, short_target_in}
                               & rmcb_pkg::ZPAGE_LAST_ADDR;
        end else if (pattern_in) begin
            fetch_d.fetch_en = 1'b1; // Pattern window
            fetch_d.fetch_addr = {2'b00, pattern_addr_in}
                               & rmcb_pkg::PAT_LAST_ADDR;
        end
        // Memory register digit read for load and swap
        mr_d = ram_q[{6'h04, memreg_idx_in}];
    end

    // --------------------
    // RAM, including stack data and memory register digits
    // --------------------
    always_ff @(posedge core_clk_in) begin
        if (call_in || irq_entry_in) begin
            ram_q[sp_q]                       <= pc_in[13:10];
            ram_q[{4'hf, 6'(sp_q[5:0] - 6'h01)}] <= pc_in[9:6];
            ram_q[{4'hf, 6'(sp_q[5:0] - 6'h02)}] <= pc_in[5:2];
            ram_q[{4'hf, 6'(sp_q[5:0] - 6'h03)}] <= {pc_in[1:0], st_in, ca_in};
        end else if (memreg_swap_in)
            ram_q[{6'h04, memreg_idx_in}] <= acc_in;
        else if (ram_we_in && ram_addr_in > rmcb_pkg::SPEC_B_LAST)
            ram_q[ram_addr_in] <= ram_wdata_in; // Free stack is data
    end

    // --------------------
    // Control registers
    // --------------------
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            irq0_q <= rmcb_pkg::RST_WAKEUP;
            irq1_q <= rmcb_pkg::RST_EXT;
            irq2_q <= rmcb_pkg::RST_TIMER;
            irq3_q <= rmcb_pkg::RST_CONV;
            sys_q <= rmcb_pkg::RST_SYSTEM; // Watchdog cleared only here
            gear_q <= rmcb_pkg::RST_GEAR;
            ser_q <= rmcb_pkg::RST_SERIAL;
            pend_q <= 7'h00;
            sp_q <= rmcb_pkg::STACK_TOP;
            tv_q <= 1'b0;
            tr_q <= 1'b0;
            tu_q <= 1'b0;
            rdata_q <= 4'h0;
            mr_q <= 4'h0;
            frame_q <= '0;
            rv_q <= 1'b0;
            rf_q <= 1'b0;
            fetch_q <= '{fetch_addr: 14'h0000, fetch_en: 1'b1};
        end else begin
            irq0_q <= irq0_d;
            irq1_q <= irq1_d;
            irq2_q <= irq2_d;
            irq3_q <= irq3_d;
            sys_q <= sys_d;
            gear_q <= gear_d;
            ser_q <= ser_d;
            pend_q <= pend_d;
            sp_q <= sp_d;
            tv_q <= tv_d;
            tr_q <= tr_d;
            tu_q <= tu_d;
            rdata_q <= rdata_d;
            mr_q <= mr_d;
            frame_q <= frame_d;
            rv_q <= rv_d;
            rf_q <= rf_d;
            fetch_q <= fetch_d;
        end
    end

    // Outputs straight from flip-flops
    assign test_valid_out = tv_q;
    assign test_result_out = tr_q;
    assign test_undef_out = tu_q;
    assign ram_rdata_out = rdata_q;
    assign memreg_out = mr_q;
    assign stack_ptr_out = sp_q;
    assign restore_out = frame_q;
    assign restore_valid_out = rv_q;
    assign restore_flags_out = rf_q;
    assign fetch_out = fetch_q;
    assign irq_pend_out = pend_q;
    assign global_irq_allow_out = irq0_q[0];
    assign watchdog_run_out = sys_q[1];
    assign adc_start_out = sys_q[2];
    assign low_speed_out = sys_q[0];
    assign gear_enable_out = gear_q[3];
    assign direct_transfer_out = sys_q[3];

endmodule

// ---- rmcb_bits_monitor.sv ----
// Checker for the RAM-mapped control bit block, bound to rmcb_bits.
// Assumes one clock domain with an asynchronous active-low reset.
`timescale 1ns/100ps
module rmcb_bits_monitor (
    input wire logic                  core_clk_in,
    input wire logic                  reset_n_in,
    input wire rmcb_pkg::rmcb_bitop_s bitop_in,
    input wire logic                  subactive_in,
    input wire logic                  call_in,
    input wire logic                  sub_ret_in,
    input wire logic                  irq_ret_in,
    input wire logic                  test_valid_out,
    input wire logic                  test_undef_out,
    input wire logic [9:0]            stack_ptr_out,
    input wire logic                  restore_valid_out,
    input wire logic                  restore_flags_out,
    input wire logic                  watchdog_run_out,
    input wire logic                  direct_transfer_out
);
    // --------------------
    // Properties, all on the core clock
    // --------------------
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!reset_n_in);

    // Test of a bit at address 000 (wakeup and global interrupt bits) answers on the next cycle
    property p_test_answer;
        bitop_in.test_op && bitop_in.addr == 10'h000 |=> test_valid_out;
    endproperty
    a_test_answer: assert property (p_test_answer)
        else $error("bit test got no answer");
    // Testing the stack clear bit is a forbidden test
    property p_undef_rsp;
        bitop_in.test_op && bitop_in.addr == 10'h000 &&
            bitop_in.bit_sel == 2'h1 |=> test_undef_out && test_valid_out;
    endproperty
    a_undef_rsp: assert property (p_undef_rsp)
        else $error("forbidden test not flagged");
    // Watchdog bit can only fall through reset
    property p_wdog_sticky;
        watchdog_run_out |=> watchdog_run_out;
    endproperty
    a_wdog_sticky: assert property (p_wdog_sticky)
        else $error("watchdog bit dropped");
    property p_direct_transfer_on_active;
        !subactive_in |=> !direct_transfer_out;
    endproperty
    a_direct_transfer_on_active: assert property (p_direct_transfer_on_active)
        else $error("direct transfer set in active mode");
    // Push moves the pointer down one four-digit level
    property p_push_sp;
        call_in && !bitop_in.clear_op |=> stack_ptr_out ==
            {4'hf, $past(stack_ptr_out[5:0]) - 6'h04};
    endproperty
    a_push_sp: assert property (p_push_sp)
        else $error("stack pointer wrong after push");
    property p_sub_ret;
        sub_ret_in |=> restore_valid_out && !restore_flags_out;
    endproperty
    a_sub_ret: assert property (p_sub_ret)
        else $error("subroutine return restored flags");
    property p_irq_ret;
        irq_ret_in |=> restore_valid_out && restore_flags_out;
    endproperty
    a_irq_ret: assert property (p_irq_ret)
        else $error("interrupt return lost flags");
    property p_rsp_clear;
        bitop_in.clear_op && bitop_in.addr == 10'h000 &&
            bitop_in.bit_sel == 2'h1 |=> stack_ptr_out == 10'h3ff;
    endproperty
    a_rsp_clear: assert property (p_rsp_clear)
        else $error("stack clear did not reload pointer");

    // Main scenarios reached
    c_call: cover property (call_in ##[1:8] sub_ret_in);
    c_irq_ret: cover property (irq_ret_in);
    c_undef: cover property (test_undef_out);
endmodule

bind rmcb_bits rmcb_bits_monitor u_mon (.*);

// ---- rmcb_bits_test.sv ----
// Self-checking bench for the RAM-mapped control bit block.
// Assumes rmcb_bits alone; inputs move 1 ns after each rising edge.
`timescale 1ns/100ps
module rmcb_bits_test;
    // --------------------
    // Stimulus and observed signals
    // --------------------
    logic                  core_clk_in = 1'h0;
    logic                  reset_n_in = 1'h0;
    rmcb_pkg::rmcb_bitop_s bitop_in = '0;
    rmcb_pkg::rmcb_evt_s   evt_in = '0;
    logic subactive_in = 1'h0, call_in = 1'h0, irq_entry_in = 1'h0;
    logic sub_ret_in = 1'h0, irq_ret_in = 1'h0, st_in = 1'h0, ca_in = 1'h0;
    logic short_call_in = 1'h0, pattern_in = 1'h0, ram_we_in = 1'h0;
    logic memreg_swap_in = 1'h0;
    logic [1:0]  irq_vec_in = 2'h0;
    logic [13:0] pc_in = 14'h0;
    logic [5:0]  short_target_in = 6'h0;
    logic [11:0] pattern_addr_in = 12'h0;
    logic [9:0]  ram_addr_in = 10'h0;
    logic [3:0]  ram_wdata_in = 4'h0, memreg_idx_in = 4'h0, acc_in = 4'h0;
    logic test_valid_out, test_result_out, test_undef_out, restore_valid_out;
    logic restore_flags_out, global_irq_allow_out, watchdog_run_out;
    logic adc_start_out, low_speed_out, gear_enable_out, direct_transfer_out;
    logic [3:0]  ram_rdata_out, memreg_out;
    logic [9:0]  stack_ptr_out;
    logic [6:0]  irq_pend_out;
    rmcb_pkg::rmcb_frame_s restore_out;
    rmcb_pkg::rmcb_fetch_s fetch_out;
    int errors = 0;
    int samples_checked = 0;

    rmcb_bits uut (.*);

    // 100 MHz core clock
    always #5 core_clk_in = ~core_clk_in;

    // --------------------
    // Shared tasks
    // --------------------
    task automatic tick();
        @(posedge core_clk_in);
        #1;
    endtask
    task automatic chk_val(input string what, input logic [15:0] exp,
                           input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk_bit(input string what, input logic exp, got);
        chk_val(what, {15'h0, exp}, {15'h0, got});
    endtask
    // Kind {set, clear, test}; idle edge first, op stands one cycle
    task automatic bit_op(input logic [2:0] k, input logic [9:0] a,
                          input logic [1:0] s);
        tick();
        bitop_in = '{set_op: k[2], clear_op: k[1], test_op: k[0],
                     addr: a, bit_sel: s};
        tick();
        bitop_in = '0;
    endtask
    task automatic test_bit(input logic [9:0] a, input logic [1:0] s,
                            input logic exp, undef);
        bit_op(3'h1, a, s);
        chk_bit("test_valid", 1'h1, test_valid_out);
        chk_bit("test_undef", undef, test_undef_out);
        if (!undef) chk_bit("test_result", exp, test_result_out);
    endtask
    // Read data is registered one edge after the address
    task automatic ram_chk(input logic [9:0] a, input logic [3:0] exp);
        ram_addr_in = a;
        tick();
        chk_val("ram_rdata", {12'h0, exp}, {12'h0, ram_rdata_out});
    endtask
    task automatic tally_and_finish();
        if (errors == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // --------------------
    // Scenarios
    // --------------------
    task automatic t_reset();
        chk_bit("fetch_en", 1'h1, fetch_out.fetch_en);
        chk_val("fetch_addr", 16'h0, {2'h0, fetch_out.fetch_addr});
        chk_val("stack_ptr", 16'h3ff, {6'h0, stack_ptr_out});
        chk_val("irq_pend", 16'h0, {9'h0, irq_pend_out});
        chk_bit("irq_allow", 1'h0, global_irq_allow_out);
    endtask
    // Entries are {addr, bit, value}: masks read 1, flags 0
    task automatic t_layout();
        logic [12:0] tb [13] = '{13'h007, 13'h004, 13'h000, 13'h00b,
            13'h008, 13'h017, 13'h013, 13'h01f, 13'h01b, 13'h11f, 13'h11c,
            13'h100, 13'h104};
        foreach (tb[i])
            test_bit(tb[i][12:3], tb[i][2:1], tb[i][0], 1'h0);
    endtask
    // Request flags by pending-bit index, serial first; mask is bit+1
    task automatic t_flags();
        logic [9:0] fa [7] = '{10'h023, 10'h003, 10'h003, 10'h002,
                               10'h002, 10'h001, 10'h000};
        logic [1:0] fb [7] = '{2'h2, 2'h2, 2'h0, 2'h2, 2'h0, 2'h0, 2'h2};
        for (int k = 0; k < 7; k++) begin
            bit_op(3'h4, fa[k], fb[k]);
            test_bit(fa[k], fb[k], 1'h0, 1'h0);
            evt_in = rmcb_pkg::rmcb_evt_s'(7'h01 << k);
            tick();
            evt_in = '0;
            test_bit(fa[k], fb[k], 1'h1, 1'h0);
            chk_val("irq_pend", 16'h0, {9'h0, irq_pend_out});
            bit_op(3'h2, fa[k], fb[k] + 2'h1);
            chk_val("irq_pend", 16'h1 << k, {9'h0, irq_pend_out});
            bit_op(3'h2, fa[k], fb[k]);
            chk_val("irq_pend", 16'h0, {9'h0, irq_pend_out});
            bit_op(3'h4, fa[k], fb[k] + 2'h1);
        end
    endtask
    task automatic t_system();
        bit_op(3'h4, 10'h000, 2'h0);
        chk_bit("irq_allow", 1'h1, global_irq_allow_out);
        bit_op(3'h2, 10'h000, 2'h0);
        chk_bit("irq_allow", 1'h0, global_irq_allow_out);
        bit_op(3'h4, 10'h020, 2'h1);
        bit_op(3'h2, 10'h020, 2'h1);
        chk_bit("watchdog", 1'h1, watchdog_run_out);
        test_bit(10'h020, 2'h1, 1'h0, 1'h1);
        bit_op(3'h4, 10'h020, 2'h2);
        chk_bit("adc_start", 1'h1, adc_start_out);
        test_bit(10'h020, 2'h2, 1'h1, 1'h0);
        bit_op(3'h4, 10'h020, 2'h0);
        chk_bit("low_speed", 1'h1, low_speed_out);
        bit_op(3'h4, 10'h021, 2'h3);
        chk_bit("gear", 1'h1, gear_enable_out);
        bit_op(3'h2, 10'h021, 2'h3);
        chk_bit("gear", 1'h0, gear_enable_out);
        test_bit(10'h021, 2'h3, 1'h0, 1'h1);
        test_bit(10'h022, 2'h0, 1'h0, 1'h1);
        test_bit(10'h000, 2'h1, 1'h0, 1'h1);
        bit_op(3'h4, 10'h020, 2'h3);
        chk_bit("direct_transfer_on", 1'h0, direct_transfer_out);
        subactive_in = 1'h1;
        bit_op(3'h4, 10'h020, 2'h3);
        chk_bit("direct_transfer_on", 1'h1, direct_transfer_out);
        subactive_in = 1'h0;
        tick();
        chk_bit("direct_transfer_on", 1'h0, direct_transfer_out);
    endtask
    task automatic t_stack();
        pc_in = 14'h2a5c;
        st_in = 1'h1;
        call_in = 1'h1;
        tick();
        call_in = 1'h0;
        chk_val("stack_ptr", 16'h3fb, {6'h0, stack_ptr_out});
        ram_chk(10'h3ff, 4'ha);
        ram_chk(10'h3fc, 4'h2);
        pc_in = 14'h1357;
        st_in = 1'h0;
        ca_in = 1'h1;
        irq_vec_in = 2'h3;
        irq_entry_in = 1'h1;
        tick();
        irq_entry_in = 1'h0;
        chk_bit("fetch_en", 1'h1, fetch_out.fetch_en);
        chk_val("vec_page", 16'h0, {6'h0, fetch_out.fetch_addr[13:4]});
        chk_val("stack_ptr", 16'h3f7, {6'h0, stack_ptr_out});
        irq_ret_in = 1'h1;
        tick();
        irq_ret_in = 1'h0;
        chk_bit("restore_flags", 1'h1, restore_flags_out);
        chk_val("restore", 16'h4d5d, restore_out);
        sub_ret_in = 1'h1;
        tick();
        sub_ret_in = 1'h0;
        chk_bit("restore_valid", 1'h1, restore_valid_out);
        chk_bit("restore_flags", 1'h0, restore_flags_out);
        chk_val("restore_pc", 16'h2a5c, {2'h0, restore_out.pc});
        call_in = 1'h1;
        tick();
        call_in = 1'h0;
        bit_op(3'h2, 10'h000, 2'h1);
        chk_val("stack_ptr", 16'h3ff, {6'h0, stack_ptr_out});
        ram_chk(10'h3e0, 4'hx);
        ram_addr_in = 10'h3f0;
        ram_wdata_in = 4'h6;
        ram_we_in = 1'h1;
        tick();
        ram_we_in = 1'h0;
        ram_chk(10'h3f0, 4'h6);
        memreg_idx_in = 4'h5;
        acc_in = 4'h9;
        memreg_swap_in = 1'h1;
        tick();
        memreg_swap_in = 1'h0;
        tick();
        chk_val("memreg", 16'h9, {12'h0, memreg_out});
        ram_chk(10'h045, 4'h9);
    endtask
    task automatic t_fetch();
        short_target_in = 6'h2b;
        short_call_in = 1'h1;
        tick();
        short_call_in = 1'h0;
        chk_bit("fetch_en", 1'h1, fetch_out.fetch_en);
        chk_val("fetch_addr", 16'h2b, {2'h0, fetch_out.fetch_addr});
        pattern_addr_in = 12'hfff;
        pattern_in = 1'h1;
        tick();
        pattern_in = 1'h0;
        chk_val("fetch_addr", 16'hfff, {2'h0, fetch_out.fetch_addr});
    endtask

    // Reset for five cycles, then the scenarios in turn
    initial begin
        repeat (5) @(posedge core_clk_in);
        #1;
        t_reset();
        reset_n_in = 1'h1;
        tick();
        t_layout();
        t_flags();
        t_system();
        t_stack();
        t_fetch();
        tally_and_finish();
    end
    // Run needs under a thousand cycles; this bounds a hang
    initial begin
        #100000;
        errors++;
        tally_and_finish();
    end
endmodule
